// ===== gdp_defs.vh
`ifndef GDP_DEFS_VH
`define GDP_DEFS_VH

`define GDP_ADDR_X_DATA 8'hC0
`define GDP_ADDR_LY_DATA 8'hC2
`define GDP_ADDR_HY_DATA 8'hC4
`define GDP_ADDR_X_DIR 8'hC6
`define GDP_ADDR_LY_DIR 8'hC7
`define GDP_ADDR_HY_DIR 8'hC8
`define GDP_ADDR_HY_ODE 8'hE4
`define GDP_ADDR_HY_ODM 8'hE5

`define GDP_MASK_MSB 15
`define GDP_MASK_LSB 8
`define GDP_DATA_MSB 7
`define GDP_DATA_LSB 0
`define GDP_HY_MASK_MSB 11
`define GDP_HY_DATA_MSB 3

`define GDP_RST_X_DATA 8'hFC
`define GDP_RST_LY_DATA 8'h00
`define GDP_RST_HY_DATA 4'h0
`define GDP_RST_X_DIR 8'h00
`define GDP_RST_LY_DIR 8'h00
`define GDP_RST_HY_DIR 4'h8
`define GDP_RST_HY_ODE 4'h8
`define GDP_RST_HY_ODM 4'h0
`define GDP_RST_MASK 8'h00
`define GDP_RST_HY_MASK 4'h0

`endif

// ===== gdp_pin_sync.v
`timescale 1ns/1ns
`include "gdp_defs.vh"

// three-stage pin synchroniser; output changes once stages two and three agree
module gdp_pin_sync #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rstn,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_q
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer i;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ===== gdp_port.v
`timescale 1ns/1ns
`include "gdp_defs.vh"

// Function
// - An open-drain high Y-line pin drives only low when its select is 0 and only high when 1, select resets to 0.
// - A data write changes an output pin only where the matching mask bit is 1.
// - Reading a data register gives the live level of input pins regardless of mask.
// - The data field read returns sensed pin levels, not the written value.
// - X and low Y data registers hold mask in bits 15:8 and data in bits 7:0.
// - High Y data register holds mask in 11:8, data in 3:0, other bits reserved.
// - A direction bit of 0 makes the pin an input and 1 an output.
// - X data resets to 0xFC, low Y data to 0x00, and X and low Y directions to 0x00.
// - High Y direction resets to 0x08 with bits 7:4 reserved.
// - All mask bits reset to 0; each data write applies the mask field it carries, not the stored mask.
// - Each high Y-line pin's open-drain enable picks push-pull at 0 and open-drain at 1.
// - The top high Y-line pin defaults to open-drain, enable field reset 0x8.
module gdp_port (
  core_clk,
  rstn,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  x_line_pins_in,
  x_line_pins_out,
  x_line_pins_oe,
  low_y_line_pins_in,
  low_y_line_pins_out,
  low_y_line_pins_oe,
  high_y_line_pins_in,
  high_y_line_pins_out,
  high_y_line_pins_oe
);
  input wire core_clk;
  input wire rstn;
  input wire [7:0] reg_addr;
  input wire reg_wr;
  input wire reg_rd;
  input wire [15:0] reg_wdata;
  output reg [15:0] reg_rdata;
  input wire [7:0] x_line_pins_in;
  output reg [7:0] x_line_pins_out;
  output reg [7:0] x_line_pins_oe;
  input wire [7:0] low_y_line_pins_in;
  output reg [7:0] low_y_line_pins_out;
  output reg [7:0] low_y_line_pins_oe;
  input wire [3:0] high_y_line_pins_in;
  output reg [3:0] high_y_line_pins_out;
  output reg [3:0] high_y_line_pins_oe;

  reg [7:0] x_data_q;
  reg [7:0] ly_data_q;
  reg [3:0] hy_data_q;
  reg [7:0] x_write_mask_q;
  reg [7:0] low_y_write_mask_q;
  reg [3:0] high_y_write_mask_q;
  reg [7:0] x_direction_bits_q;
  reg [7:0] low_y_direction_bits_q;
  reg [3:0] high_y_direction_bits_q;
  reg [3:0] open_drain_enable_q;
  reg [3:0] drain_source_select_q;
  reg [15:0] rdata_d;
  reg [3:0] hy_out_d;
  reg [3:0] hy_oe_d;
  wire [19:0] sensed;
  wire [7:0] x_sensed;
  wire [7:0] ly_sensed;
  wire [3:0] hy_sensed;
  reg [7:0] x_data_d;
  reg [7:0] ly_data_d;
  reg [3:0] hy_data_d;
  reg [7:0] x_write_mask_d;
  reg [7:0] low_y_write_mask_d;
  reg [3:0] high_y_write_mask_d;
  reg [7:0] x_direction_bits_d;
  reg [7:0] low_y_direction_bits_d;
  reg [3:0] high_y_direction_bits_d;
  reg [3:0] open_drain_enable_d;
  reg [3:0] drain_source_select_d;
  reg [7:0] x_out_d;
  reg [7:0] x_oe_d;
  reg [7:0] ly_out_d;
  reg [7:0] ly_oe_d;
  wire wr_x_data;
  wire wr_ly_data;
  wire wr_hy_data;
  wire wr_x_dir;
  wire wr_ly_dir;
  wire wr_hy_dir;
  wire wr_hy_ode;
  wire wr_hy_odm;
  integer i;

  gdp_pin_sync #(
    .WIDTH(20)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin_in({high_y_line_pins_in, low_y_line_pins_in, x_line_pins_in}),
    .level_q(sensed)
  );

  assign x_sensed = sensed[7:0];
  assign ly_sensed = sensed[15:8];
  assign hy_sensed = sensed[19:16];

  // merge written data under the mask
  function [7:0] masked_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
      masked_merge = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // four-bit variant for the high Y-line group
  function [3:0] masked_merge4;
    input [3:0] old_val;
    input [3:0] new_val;
    input [3:0] mask;
    begin
      masked_merge4 = (old_val & ~mask) | (new_val & mask);
    end
  endfunction

  // address match for one register
  function reg_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      reg_hit = (addr == target);
    end
  endfunction

  // one write strobe per register
  assign wr_x_data = reg_wr & reg_hit(reg_addr, `GDP_ADDR_X_DATA);
  assign wr_ly_data = reg_wr & reg_hit(reg_addr, `GDP_ADDR_LY_DATA);
  assign wr_hy_data = reg_wr & reg_hit(reg_addr, `GDP_ADDR_HY_DATA);
  assign wr_x_dir = reg_wr & reg_hit(reg_addr, `GDP_ADDR_X_DIR);
  assign wr_ly_dir = reg_wr & reg_hit(reg_addr, `GDP_ADDR_LY_DIR);
  assign wr_hy_dir = reg_wr & reg_hit(reg_addr, `GDP_ADDR_HY_DIR);
  assign wr_hy_ode = reg_wr & reg_hit(reg_addr, `GDP_ADDR_HY_ODE);
  assign wr_hy_odm = reg_wr & reg_hit(reg_addr, `GDP_ADDR_HY_ODM);

  // register next values
  always @* begin
    x_data_d = x_data_q;
    ly_data_d = ly_data_q;
    hy_data_d = hy_data_q;
    x_write_mask_d = x_write_mask_q;
    low_y_write_mask_d = low_y_write_mask_q;
    high_y_write_mask_d = high_y_write_mask_q;
    x_direction_bits_d = x_direction_bits_q;
    low_y_direction_bits_d = low_y_direction_bits_q;
    high_y_direction_bits_d = high_y_direction_bits_q;
    open_drain_enable_d = open_drain_enable_q;
    drain_source_select_d = drain_source_select_q;
    if (wr_x_data) begin
      x_write_mask_d = reg_wdata[`GDP_MASK_MSB:`GDP_MASK_LSB];
      x_data_d = masked_merge(x_data_q,
        reg_wdata[`GDP_DATA_MSB:`GDP_DATA_LSB],
        reg_wdata[`GDP_MASK_MSB:`GDP_MASK_LSB]);
    end
    if (wr_ly_data) begin
      low_y_write_mask_d = reg_wdata[`GDP_MASK_MSB:`GDP_MASK_LSB];
      ly_data_d = masked_merge(ly_data_q,
        reg_wdata[`GDP_DATA_MSB:`GDP_DATA_LSB],
        reg_wdata[`GDP_MASK_MSB:`GDP_MASK_LSB]);
    end
    if (wr_hy_data) begin
      high_y_write_mask_d = reg_wdata[`GDP_HY_MASK_MSB:`GDP_MASK_LSB];
      hy_data_d = masked_merge4(hy_data_q,
        reg_wdata[`GDP_HY_DATA_MSB:`GDP_DATA_LSB],
        reg_wdata[`GDP_HY_MASK_MSB:`GDP_MASK_LSB]);
    end
    if (wr_x_dir) begin
      x_direction_bits_d = reg_wdata[`GDP_DATA_MSB:`GDP_DATA_LSB];
    end
    if (wr_ly_dir) begin
      low_y_direction_bits_d = reg_wdata[`GDP_DATA_MSB:`GDP_DATA_LSB];
    end
    if (wr_hy_dir) begin
      high_y_direction_bits_d = reg_wdata[`GDP_HY_DATA_MSB:`GDP_DATA_LSB];
    end
    if (wr_hy_ode) begin
      open_drain_enable_d = reg_wdata[`GDP_HY_DATA_MSB:`GDP_DATA_LSB];
    end
    if (wr_hy_odm) begin
      drain_source_select_d = reg_wdata[`GDP_HY_DATA_MSB:`GDP_DATA_LSB];
    end
  end

  // output latch and config registers
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      x_data_q <= `GDP_RST_X_DATA;
      ly_data_q <= `GDP_RST_LY_DATA;
      hy_data_q <= `GDP_RST_HY_DATA;
      x_write_mask_q <= `GDP_RST_MASK;
      low_y_write_mask_q <= `GDP_RST_MASK;
      high_y_write_mask_q <= `GDP_RST_HY_MASK;
      x_direction_bits_q <= `GDP_RST_X_DIR;
      low_y_direction_bits_q <= `GDP_RST_LY_DIR;
      high_y_direction_bits_q <= `GDP_RST_HY_DIR;
      open_drain_enable_q <= `GDP_RST_HY_ODE;
      drain_source_select_q <= `GDP_RST_HY_ODM;
    end else begin
      x_data_q <= x_data_d;
      ly_data_q <= ly_data_d;
      hy_data_q <= hy_data_d;
      x_write_mask_q <= x_write_mask_d;
      low_y_write_mask_q <= low_y_write_mask_d;
      high_y_write_mask_q <= high_y_write_mask_d;
      x_direction_bits_q <= x_direction_bits_d;
      low_y_direction_bits_q <= low_y_direction_bits_d;
      high_y_direction_bits_q <= high_y_direction_bits_d;
      open_drain_enable_q <= open_drain_enable_d;
      drain_source_select_q <= drain_source_select_d;
    end
  end

  // read mux
  always @* begin
    rdata_d = 16'h0000;
    case (reg_addr)
      `GDP_ADDR_X_DATA: rdata_d = {x_write_mask_q, x_sensed};
      `GDP_ADDR_LY_DATA: rdata_d = {low_y_write_mask_q, ly_sensed};
      `GDP_ADDR_HY_DATA: rdata_d = {4'h0, high_y_write_mask_q, 4'h0,
        hy_sensed};
      `GDP_ADDR_X_DIR: rdata_d = {8'h00, x_direction_bits_q};
      `GDP_ADDR_LY_DIR: rdata_d = {8'h00, low_y_direction_bits_q};
      `GDP_ADDR_HY_DIR: rdata_d = {12'h000, high_y_direction_bits_q};
      `GDP_ADDR_HY_ODE: rdata_d = {12'h000, open_drain_enable_q};
      `GDP_ADDR_HY_ODM: rdata_d = {12'h000, drain_source_select_q};
      default: rdata_d = 16'h0000;
    endcase
  end

  // high Y-line driver selection
  always @* begin
    hy_out_d = hy_data_q;
    hy_oe_d = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (!high_y_direction_bits_q[i]) begin
        hy_oe_d[i] = 1'b0;
      end else if (!open_drain_enable_q[i]) begin
        hy_oe_d[i] = 1'b1;
      end else begin
        hy_out_d[i] = drain_source_select_q[i];
        hy_oe_d[i] = (hy_data_q[i] == drain_source_select_q[i]);
      end
    end
  end

  // direction gates drive
  // x and low Y lines are always push-pull
  always @* begin
    x_out_d = x_data_q;
    x_oe_d = x_direction_bits_q;
    ly_out_d = ly_data_q;
    ly_oe_d = low_y_direction_bits_q;
  end

  // registered pin and read outputs
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      x_line_pins_out <= 8'h00;
      x_line_pins_oe <= 8'h00;
      low_y_line_pins_out <= 8'h00;
      low_y_line_pins_oe <= 8'h00;
      high_y_line_pins_out <= 4'h0;
      high_y_line_pins_oe <= 4'h0;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      x_line_pins_out <= x_out_d;
      x_line_pins_oe <= x_oe_d;
      low_y_line_pins_out <= ly_out_d;
      low_y_line_pins_oe <= ly_oe_d;
      high_y_line_pins_out <= hy_out_d;
      high_y_line_pins_oe <= hy_oe_d;
    end
  end
endmodule

// ===== gdp_port_chk.sv
`timescale 1ns/1ns
`include "gdp_defs.vh"
module gdp_port_chk (
  input wire core_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire [7:0] x_line_pins_out,
  input wire [7:0] x_line_pins_oe,
  input wire [3:0] high_y_line_pins_out,
  input wire [3:0] high_y_line_pins_oe
);
  logic ode_q;
  logic sel_q;
  wire x_wr = reg_wr && reg_addr == `GDP_ADDR_X_DATA;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // shadow of the top high Y-line drain settings
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ode_q <= 1'b1;
      sel_q <= 1'b0;
    end else if (reg_wr && reg_addr == `GDP_ADDR_HY_ODE) begin
      ode_q <= reg_wdata[3];
    end else if (reg_wr && reg_addr == `GDP_ADDR_HY_ODM) begin
      sel_q <= reg_wdata[3];
    end
  end
  sequence s_dir_wr;
    reg_wr && reg_addr == `GDP_ADDR_LY_DIR;
  endsequence
  sequence s_dir_rd;
    reg_rd && reg_addr == `GDP_ADDR_LY_DIR;
  endsequence
  a_unmapped_read: assert property (reg_rd
    && reg_addr == 8'hC1 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_hy_data_rsvd: assert property (reg_rd
    && reg_addr == `GDP_ADDR_HY_DATA
    |=> reg_rdata[15:12] == 4'h0 && reg_rdata[7:4] == 4'h0)
    else $error("reserved data bits not zero");
  a_hy_dir_rsvd: assert property (reg_rd
    && reg_addr == `GDP_ADDR_HY_DIR |=> reg_rdata[15:4] == 12'h000)
    else $error("reserved dir bits set");
  a_x_dir_oe: assert property (reg_wr
    && reg_addr == `GDP_ADDR_X_DIR
    |-> ##2 x_line_pins_oe == $past(reg_wdata[7:0], 2))
    else $error("x enables differ from direction");
  a_x_mask_hold: assert property (x_wr |-> ##2
    ((x_line_pins_out ^ $past(x_line_pins_out)) & ~$past(reg_wdata[15:8], 2))
    == 8'h00) else $error("masked x pin changed");
  a_x_mask_write: assert property (x_wr |-> ##2
    ((x_line_pins_out ^ $past(reg_wdata[7:0], 2)) & x_line_pins_oe
    & $past(reg_wdata[15:8], 2)) == 8'h00) else $error("x pin not written");
  a_dir_readback: assert property (s_dir_wr ##1 s_dir_rd |=>
    reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)})
    else $error("direction readback wrong");
  a_drain_source: assert property ($past(ode_q)
    && high_y_line_pins_oe[3] |-> high_y_line_pins_out[3] == $past(sel_q))
    else $error("open drain drives wrong level");
endmodule
bind gdp_port gdp_port_chk chk (
  .core_clk(core_clk),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .x_line_pins_out(x_line_pins_out),
  .x_line_pins_oe(x_line_pins_oe),
  .high_y_line_pins_out(high_y_line_pins_out),
  .high_y_line_pins_oe(high_y_line_pins_oe)
);

// ===== gdp_pin_model.sv
`timescale 1ns/1ns
module gdp_pin_model (
  input wire [19:0] out,
  input wire [19:0] oe,
  input wire [19:0] ext,
  output wire [19:0] level
);
  // a released pin follows whatever the far side drives
  assign level = (out & oe) | (ext & ~oe);
endmodule

// ===== test_gdp_port.sv
`timescale 1ns/1ns
`include "gdp_defs.vh"
module test_gdp_port;
  logic core_clk = 0;
  logic rstn = 0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [19:0] ext = 20'h00000;
  wire [15:0] reg_rdata;
  wire [19:0] p_out;
  wire [19:0] p_oe;
  wire [19:0] lvl;
  int err_count = 0;
  int total_checks = 0;
  gdp_port uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .x_line_pins_in(lvl[7:0]),
    .x_line_pins_out(p_out[7:0]), .x_line_pins_oe(p_oe[7:0]),
    .low_y_line_pins_in(lvl[15:8]), .low_y_line_pins_out(p_out[15:8]),
    .low_y_line_pins_oe(p_oe[15:8]), .high_y_line_pins_in(lvl[19:16]),
    .high_y_line_pins_out(p_out[19:16]), .high_y_line_pins_oe(p_oe[19:16]));
  gdp_pin_model pins (.out(p_out), .oe(p_oe), .ext(ext), .level(lvl));
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge core_clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string w);
    reg_addr = a;
    reg_rd = 1;
    step(1);
    reg_rd = 0;
    step(1);
    chk(reg_rdata, e, w);
  endtask
  task automatic t_reset();
    chk(p_out[7:0], 16'h00FC, "x out");
    chk(p_out[15:8], 16'h0000, "ly out");
    chk(p_oe[15:0], 16'h0000, "x ly oe");
    chk({p_oe[19:16], p_out[19:16]}, 16'h0080, "hy pins");
    rd(`GDP_ADDR_X_DIR, 16'h0000, "x dir");
    rd(`GDP_ADDR_LY_DIR, 16'h0000, "ly dir");
    rd(`GDP_ADDR_HY_DIR, 16'h0008, "hy dir");
    rd(`GDP_ADDR_HY_ODM, 16'h0000, "hy odm");
    rd(`GDP_ADDR_HY_ODE, 16'h0008, "hy ode");
    $display("reset test done");
  endtask
  task automatic t_mask();
    wr(`GDP_ADDR_X_DIR, 16'h00FF);
    wr(`GDP_ADDR_X_DATA, 16'h00AA);
    step(3);
    chk(p_out[7:0], 16'h00FC, "x held");
    chk(p_oe[7:0], 16'h00FF, "x oe");
    wr(`GDP_ADDR_X_DATA, 16'h0F55);
    step(8);
    chk(p_out[7:0], 16'h00F5, "x masked");
    rd(`GDP_ADDR_X_DATA, 16'h0FF5, "x data");
    ext[7:0] = 8'h3C;
    wr(`GDP_ADDR_X_DIR, 16'h0000);
    step(8);
    rd(`GDP_ADDR_X_DATA, 16'h0F3C, "x input");
    $display("mask test done");
  endtask
  task automatic t_high();
    ext[19:16] = 4'h5;
    wr(`GDP_ADDR_HY_DATA, 16'hFFFF);
    step(8);
    chk(p_oe[19:16], 16'h0000, "hy released");
    rd(`GDP_ADDR_HY_DATA, 16'h0F05, "hy data");
    wr(`GDP_ADDR_HY_ODM, 16'h00F8);
    step(8);
    chk({p_oe[19:16], p_out[19:16]}, 16'h008F, "hy high");
    rd(`GDP_ADDR_HY_DATA, 16'h0F0D, "hy sensed");
    rd(`GDP_ADDR_HY_ODM, 16'h0008, "odm rsvd");
    rd(8'hC1, 16'h0000, "unmapped");
    wr(`GDP_ADDR_HY_DATA, 16'h0800);
    step(3);
    chk(p_oe[19:16], 16'h0000, "hy od low");
    wr(`GDP_ADDR_HY_ODE, 16'h0000);
    step(3);
    chk({p_oe[19:16], p_out[19:16]}, 16'h0087, "push pull");
    $display("high y test done");
  endtask
  task automatic t_dir();
    wr(`GDP_ADDR_LY_DIR, 16'h00A5);
    rd(`GDP_ADDR_LY_DIR, 16'h00A5, "ly dir");
    chk(p_oe[15:8], 16'h00A5, "ly oe");
    wr(`GDP_ADDR_LY_DATA, 16'hFFFF);
    step(8);
    chk(p_out[15:8], 16'h00FF, "ly out");
    rd(`GDP_ADDR_LY_DATA, 16'hFFA5, "ly data");
    $display("direction test done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    test_done();
  end
  initial begin
    step(16);
    rstn = 1;
    step(2);
    t_reset();
    t_mask();
    t_high();
    t_dir();
    test_done();
  end
endmodule
